// file: src/cfg_regs.sv
// Configuration register bank: parallel irq, power and pin muxing, clocks, id
//
// Function
// - Parallel polarity bit set inverts the parallel interrupt line.
// - Open-drain bit set makes the interrupt line pull low or float only.
// - Power and pin register sits at index 06h, resets to zero.
// - Floppy tri-state with floppy powered down floats outputs, blocks inputs except disk change.
// - UART tri-state floats a powered-down UART and blocks its inputs high.
// - ECP DMA bit selects real acknowledge/request or ack=1 and floated request.
// - Power-pin enable swaps motor1/drive1 pins to inactive/power-down indicators.
// - Selective lock is sticky until reset and freezes the clock-divide bit.
// - Parallel tri-state floats parallel outputs and blocks inputs when disabled or chip powered down.
// - Clock/UART register at 07h resets zero except latched and status bits.
// - Clock-select strap latched at reset; set halves clock, floppy too unless high-rate.
// - High-rate with divide set runs floppy on undivided clock.
// - Each UART divisor bit picks divide by 13 or by 12.
// - Two status bits always mirror floppy power-down and inactive states.
// - Inactive mask bit drives the inactive pin low when configured.
// - Read-only identification register at index 08h.
// - Irq5 select makes pin open-drain rate copy, parallel uses irq7.
// - Drive-2/3 select outputs combined select, drive-2 presence read as 1.
// - Tape support makes drive-id inputs and assumes ATA 16-bit select.
// - Printer/floppy bit mirrors detect pin, reads 1 when floppy down.
// - System mode bits at 09h reset to 11; 10 is illegal.
`timescale 1ns/1ps
module cfg_regs #(
    parameter logic [7:0] CHIP_ID   = 8'h5A, // Arbitrary identification value
    parameter int         FDC_IN_W  = 4,
    parameter int         FDC_OUT_W = 6
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_nrst,
    // Index/data configuration port
    input  wire logic                 i_cfg_wr,
    input  wire logic                 i_cfg_rd,
    input  wire logic                 i_cfg_data_sel,
    input  wire logic [7:0]           i_cfg_wdata,
    output logic      [7:0]           o_cfg_rdata,
    output logic                      o_cfg_lock,
    output logic      [7:0]           o_par_ctrl,
    output logic      [1:0]           o_sys_mode,
    output logic                      o_sys_mode_illegal,
    // Internal state from the functions
    input  wire logic                 i_par_irq,
    input  wire logic                 i_par_irq_sel5,
    input  wire logic                 i_par_disabled,
    input  wire logic                 i_chip_pd,
    input  wire logic                 i_fdc_pd,
    input  wire logic                 i_fdc_idle,
    input  wire logic [1:0]           i_uart_pd,
    input  wire logic                 i_ecp_dma_req,
    input  wire logic                 i_motor_1_enable,
    input  wire logic                 i_drive_1_select,
    input  wire logic                 i_drive23_access,
    input  wire logic                 i_rate_bit0_output,
    // Pins in
    input  wire logic                 i_pin_clock_divide_select,
    input  wire logic                 i_pin_ecp_dma_acknowledge,
    input  wire logic                 i_pin_printer_floppy_detect,
    input  wire logic                 i_pin_drive2_present_input,
    input  wire logic                 i_pin_ata_16bit_chip_select,
    input  wire logic [1:0]           i_pin_drive_id,
    input  wire logic                 i_pin_disk_change,
    input  wire logic [FDC_IN_W-1:0]  i_pin_fdc_in,
    input  wire logic [4:0]           i_pin_uart1_in,
    input  wire logic [4:0]           i_pin_uart2_in,
    input  wire logic [4:0]           i_pin_par_in,
    // Pins out
    output logic                      o_irq5_out,
    output logic                      o_irq5_oe,
    output logic                      o_irq7_out,
    output logic                      o_irq7_oe,
    output logic                      o_ecp_dma_request_out,
    output logic                      o_ecp_dma_request_oe,
    output logic                      o_pin43_out,
    output logic                      o_pin45_out,
    output logic                      o_pin49_out,
    output logic                      o_pin49_oe,
    output logic                      o_fdc_out_oe,
    output logic      [1:0]           o_uart_out_oe,
    output logic                      o_par_out_oe,
    // Gated inputs toward the functions
    output logic                      o_ecp_dma_ack_int,
    output logic                      o_ident_int,
    output logic                      o_drive2_present_int,
    output logic                      o_ata_16bit_int,
    output logic      [1:0]           o_drive_id_int,
    output logic                      o_tape_full_support,
    output logic                      o_disk_change_int,
    output logic      [FDC_IN_W-1:0]  o_fdc_in_int,
    output logic      [4:0]           o_uart1_in_int,
    output logic      [4:0]           o_uart2_in_int,
    output logic      [4:0]           o_par_in_int,
    // Clock enables
    output logic                      o_mod_clk_en,
    output logic                      o_fdc_clk_en,
    output logic      [1:0]           o_baud_clk_en
);
    // ==========================================================
    // Pin synchronisers
    localparam int SW = 9 + FDC_IN_W + 15;

    logic [SW-1:0] pin_meta_reg;
    logic [SW-1:0] pin_sync_reg;
    wire  [SW-1:0] pin_raw = {i_pin_clock_divide_select, i_pin_ecp_dma_acknowledge,
                              i_pin_printer_floppy_detect, i_pin_drive2_present_input,
                              i_pin_ata_16bit_chip_select, i_pin_drive_id, i_pin_disk_change,
                              i_pin_fdc_in, i_pin_uart1_in, i_pin_uart2_in, i_pin_par_in,
                              1'b0};

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire                s_clk_sel   = pin_sync_reg[SW-1];
    wire                s_dma_ack   = pin_sync_reg[SW-2];
    wire                s_pnf       = pin_sync_reg[SW-3];
    wire                s_drive2_present_input      = pin_sync_reg[SW-4];
    wire                s_ata16     = pin_sync_reg[SW-5];
    wire [1:0]          s_drive_id  = pin_sync_reg[SW-6 -: 2];
    wire                s_dskchg    = pin_sync_reg[SW-8];
    wire [FDC_IN_W-1:0] s_fdc_in    = pin_sync_reg[SW-9 -: FDC_IN_W];
    wire [4:0]          s_uart1_in  = pin_sync_reg[15:11];
    wire [4:0]          s_uart2_in  = pin_sync_reg[10:6];
    wire [4:0]          s_par_in    = pin_sync_reg[5:1];

    // ==========================================================
    // Register port decode
    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    logic [7:0] index_reg;
    logic [7:0] pcr_reg;
    logic [7:0] pmc_reg;
    logic [7:0] tup_reg;
    logic [7:0] asc_reg;
    logic [1:0] strap_cnt_reg;
    logic       strap_done_reg;

    wire data_wr  = i_cfg_wr & i_cfg_data_sel;
    wire wr_pcr   = data_wr & hit(index_reg, cfg_regs_pkg::IDX_PAR_CTRL);
    wire wr_pmc   = data_wr & hit(index_reg, cfg_regs_pkg::IDX_PWR_PIN);
    wire wr_tup   = data_wr & hit(index_reg, cfg_regs_pkg::IDX_CLK_UART);
    wire wr_asc   = data_wr & hit(index_reg, cfg_regs_pkg::IDX_ADV_CFG);
    wire lock     = pmc_reg[cfg_regs_pkg::PMC_LOCK];
    wire strap_ld = !strap_done_reg && (strap_cnt_reg == cfg_regs_pkg::STRAP_WAIT);

    // Lock is sticky: a write can only set it; other bits write freely
    wire [7:0] pmc_next = i_cfg_wdata | {2'h0, lock, 5'h00};
    // Clock-divide bit frozen under lock, the other writable bits still land
    wire [7:0] tup_wmask = cfg_regs_pkg::WMASK_CLK_UART & {7'h7F, ~lock};
    wire [7:0] tup_next  = (tup_reg & ~tup_wmask) | (i_cfg_wdata & tup_wmask);
    wire [7:0] asc_next  = i_cfg_wdata & cfg_regs_pkg::WMASK_ADV_CFG;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            index_reg      <= 8'h00;
            pcr_reg        <= cfg_regs_pkg::RST_PAR_CTRL;
            pmc_reg        <= cfg_regs_pkg::RST_PWR_PIN;
            tup_reg        <= cfg_regs_pkg::RST_CLK_UART;
            asc_reg        <= cfg_regs_pkg::RST_ADV_CFG;
            strap_cnt_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
        end else begin
            if (i_cfg_wr && !i_cfg_data_sel)
                index_reg <= i_cfg_wdata;
            if (wr_pcr)
                pcr_reg <= i_cfg_wdata;
            if (wr_pmc)
                pmc_reg <= pmc_next;
            if (wr_asc)
                asc_reg <= asc_next;
            // Strap waits for the synchroniser to fill before it is caught
            if (!strap_done_reg)
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_ld) begin
                strap_done_reg <= 1'b1;
                tup_reg[cfg_regs_pkg::TUP_CLK_DIV] <= s_clk_sel;
            end else if (wr_tup) begin
                tup_reg <= tup_next;
            end
        end
    end

    // ==========================================================
    // Read-back
    wire       pnf_bit  = i_fdc_pd | s_pnf;
    wire [7:0] tup_read = {tup_reg[7], i_fdc_idle, i_fdc_pd, tup_reg[4:0]};
    wire [7:0] asc_read = {asc_reg[7:5], 1'b0, pnf_bit, asc_reg[2:0]};
    wire [7:0] data_read =
        hit(index_reg, cfg_regs_pkg::IDX_PAR_CTRL) ? pcr_reg  :
        hit(index_reg, cfg_regs_pkg::IDX_PWR_PIN)  ? pmc_reg  :
        hit(index_reg, cfg_regs_pkg::IDX_CLK_UART) ? tup_read :
        hit(index_reg, cfg_regs_pkg::IDX_CHIP_ID)  ? CHIP_ID  :
        hit(index_reg, cfg_regs_pkg::IDX_ADV_CFG)  ? asc_read : 8'h00;

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst)
            o_cfg_rdata <= 8'h00;
        else if (i_cfg_rd)
            o_cfg_rdata <= i_cfg_data_sel ? data_read : index_reg;
    end

    assign o_cfg_lock         = lock;
    assign o_par_ctrl         = pcr_reg;
    assign o_sys_mode         = asc_reg[cfg_regs_pkg::ASC_MODE_LO +: 2];
    assign o_sys_mode_illegal = (o_sys_mode == cfg_regs_pkg::MODE_ILLEGAL);

    // ==========================================================
    // Parallel interrupt pins
    wire irq_lvl   = i_par_irq ^ pcr_reg[cfg_regs_pkg::PCR_POL];
    wire od        = pcr_reg[cfg_regs_pkg::PCR_ODRAIN];
    wire irq5_rate = asc_reg[cfg_regs_pkg::ASC_IRQ5_RATE];
    wire use5      = i_par_irq_sel5 & ~irq5_rate;
    wire irq_out   = od ? 1'b0 : irq_lvl;
    wire irq_oe    = od ? ~irq_lvl : 1'b1;

    assign o_irq5_out = irq5_rate ? 1'b0 : irq_out;
    assign o_irq5_oe  = irq5_rate ? ~i_rate_bit0_output : (use5 & irq_oe);
    assign o_irq7_out = irq_out;
    assign o_irq7_oe  = ~use5 & irq_oe;

    // ==========================================================
    // Pin muxing and power-down gating
    wire ecp_dma  = pmc_reg[cfg_regs_pkg::PMC_ECP_DMA];
    wire pwr_pins = pmc_reg[cfg_regs_pkg::PMC_PWR_PINS];
    wire fdc_blk  = pmc_reg[cfg_regs_pkg::PMC_FDC_TRI] & i_fdc_pd;
    wire par_blk  = pmc_reg[cfg_regs_pkg::PMC_PAR_TRI] & (i_par_disabled | i_chip_pd);
    wire idle_pin = i_fdc_idle & ~tup_reg[cfg_regs_pkg::TUP_IDLE_MASK];
    wire drv23    = asc_reg[cfg_regs_pkg::ASC_DRV23];
    wire tape     = asc_reg[cfg_regs_pkg::ASC_TAPE];

    assign o_ecp_dma_ack_int     = ecp_dma ? s_dma_ack : 1'b1;
    assign o_ecp_dma_request_out = i_ecp_dma_req;
    assign o_ecp_dma_request_oe  = ecp_dma;
    assign o_ident_int           = 1'b1;
    assign o_pin43_out           = pwr_pins ? idle_pin : i_motor_1_enable;
    assign o_pin45_out           = pwr_pins ? i_fdc_pd : i_drive_1_select;
    assign o_pin49_out           = ~i_drive23_access;
    assign o_pin49_oe            = drv23;
    assign o_drive2_present_int  = drv23 ? 1'b1 : s_drive2_present_input;
    assign o_ata_16bit_int       = tape ? 1'b1 : s_ata16;
    assign o_drive_id_int        = tape ? s_drive_id : 2'h0;
    assign o_tape_full_support   = tape;
    // Disk change stays live so media swaps are seen during power-down
    assign o_disk_change_int     = s_dskchg;
    assign o_fdc_out_oe          = ~fdc_blk;
    assign o_fdc_in_int          = fdc_blk ? {FDC_IN_W{1'b1}} : s_fdc_in;
    assign o_par_out_oe          = ~par_blk;
    assign o_par_in_int          = par_blk ? cfg_regs_pkg::PAR_IN_BLOCKED : s_par_in;

    wire [1:0] uart_blk = {2{pmc_reg[cfg_regs_pkg::PMC_UART_TRI]}} & i_uart_pd;
    assign o_uart_out_oe  = ~uart_blk;
    assign o_uart1_in_int = uart_blk[0] ? cfg_regs_pkg::UART_IN_BLOCKED : s_uart1_in;
    assign o_uart2_in_int = uart_blk[1] ? cfg_regs_pkg::UART_IN_BLOCKED : s_uart2_in;

    // ==========================================================
    // Clock enables
    logic mod_phase_reg;
    wire  clk_div = tup_reg[cfg_regs_pkg::TUP_CLK_DIV];
    wire  hi_rate = tup_reg[cfg_regs_pkg::TUP_HI_RATE];

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst)
            mod_phase_reg <= 1'b0;
        else
            mod_phase_reg <= clk_div & ~mod_phase_reg;
    end

    assign o_mod_clk_en = ~clk_div | mod_phase_reg;
    assign o_fdc_clk_en = (clk_div & hi_rate) | o_mod_clk_en;

    // Baud prescalers run on the module rate, one per UART
    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_baud
            logic [3:0] cnt_reg;
            wire  [3:0] last = tup_reg[cfg_regs_pkg::TUP_UART1_DIV + u]
                               ? 4'(cfg_regs_pkg::BAUD_DIV_MIDI - 1)
                               : 4'(cfg_regs_pkg::BAUD_DIV_STD - 1);
            wire        wrap = o_mod_clk_en && (cnt_reg >= last);
            always_ff @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst)
                    cnt_reg <= 4'h0;
                else if (o_mod_clk_en)
                    cnt_reg <= wrap ? 4'h0 : cnt_reg + 4'h1;
            end
            assign o_baud_clk_en[u] = wrap;
        end
    endgenerate

    // ==========================================================
    // Checks
    sequence s_lock_set;
        lock;
    endsequence

    chk_lock_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        s_lock_set |=> lock)
        else $error("selective lock cleared without reset");

    chk_lock_clkdiv: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (lock && wr_tup && strap_done_reg) |=> $stable(clk_div))
        else $error("locked clock-divide bit changed");

    chk_open_drain: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        od |-> (!o_irq7_out && (o_irq7_oe == (~use5 & ~irq_lvl))))
        else $error("open-drain irq drove high");

    chk_irq_polarity: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (!od && !use5) |-> (o_irq7_out == (i_par_irq ^ pcr_reg[cfg_regs_pkg::PCR_POL])))
        else $error("irq polarity wrong");

    chk_uart_block: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (pmc_reg[cfg_regs_pkg::PMC_UART_TRI] && i_uart_pd[0]) |-> (o_uart1_in_int == 5'h1F && !o_uart_out_oe[0]))
        else $error("powered-down uart not blocked");

    chk_par_block: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (pmc_reg[cfg_regs_pkg::PMC_PAR_TRI] && i_chip_pd) |-> (o_par_in_int == 5'h13 && !o_par_out_oe))
        else $error("parallel inputs not blocked");

    chk_baud_period: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (o_baud_clk_en[0] && !clk_div && !tup_reg[cfg_regs_pkg::TUP_UART1_DIV] && $stable(tup_reg))
        |=> !o_baud_clk_en[0] [*8] ##1 !o_baud_clk_en[0] [*4] ##1 o_baud_clk_en[0])
        else $error("uart1 divide by 13 broken");

    chk_pnf_powerdown: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_fdc_pd && i_cfg_rd && i_cfg_data_sel && hit(index_reg, cfg_regs_pkg::IDX_ADV_CFG))
        |=> o_cfg_rdata[cfg_regs_pkg::ASC_PNF])
        else $error("pnf bit not 1 with floppy down");

    chk_mod_half: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (clk_div && $stable(clk_div) && o_mod_clk_en) |=> !o_mod_clk_en)
        else $error("divided clock enable not halved");

endmodule // cfg_regs

// file: src/cfg_regs_pkg.sv
// Constants for the configuration register bank
package cfg_regs_pkg;
    // ==========================================================
    // Register indexes
    localparam logic [7:0] IDX_PAR_CTRL  = 8'h04;
    localparam logic [7:0] IDX_PWR_PIN   = 8'h06;
    localparam logic [7:0] IDX_CLK_UART  = 8'h07;
    localparam logic [7:0] IDX_CHIP_ID   = 8'h08;
    localparam logic [7:0] IDX_ADV_CFG   = 8'h09;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_PAR_CTRL  = 8'h00;
    localparam logic [7:0] RST_PWR_PIN   = 8'h00;
    localparam logic [7:0] RST_CLK_UART  = 8'h00;
    localparam logic [7:0] RST_ADV_CFG   = 8'hC0;
    // Writable bits; the rest are status or reserved
    localparam logic [7:0] WMASK_CLK_UART = 8'h9F;
    localparam logic [7:0] WMASK_ADV_CFG  = 8'hE7;
    // ==========================================================
    // Field positions
    localparam int PCR_POL       = 5;
    localparam int PCR_ODRAIN    = 6;
    localparam int PMC_FDC_TRI   = 1;
    localparam int PMC_UART_TRI  = 2;
    localparam int PMC_ECP_DMA   = 3;
    localparam int PMC_PWR_PINS  = 4;
    localparam int PMC_LOCK      = 5;
    localparam int PMC_PAR_TRI   = 6;
    localparam int TUP_CLK_DIV   = 0;
    localparam int TUP_HI_RATE   = 1;
    localparam int TUP_UART1_DIV = 3;
    localparam int TUP_PD_STAT   = 5;
    localparam int TUP_IDLE_STAT = 6;
    localparam int TUP_IDLE_MASK = 7;
    localparam int ASC_IRQ5_RATE = 0;
    localparam int ASC_DRV23     = 1;
    localparam int ASC_TAPE      = 2;
    localparam int ASC_PNF       = 3;
    localparam int ASC_MODE_LO   = 6;
    // ==========================================================
    // Counts
    localparam int BAUD_DIV_STD  = 13;
    localparam int BAUD_DIV_MIDI = 12;
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    // Blocked parallel inputs: BUSY, PE, SLCT, ACK, ERR
    localparam logic [4:0] PAR_IN_BLOCKED  = 5'h13;
    // Blocked UART inputs: SIN, CTS, DSR, DCD, RI
    localparam logic [4:0] UART_IN_BLOCKED = 5'h1F;
    localparam logic [1:0] MODE_ILLEGAL    = 2'h2;
endpackage

// file: test/tb_top.sv
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
module tb_top;
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
    // ==========================================================
    // Stimulus and observed signals
    logic       clk, nrst, wr, rd, sel, par_irq, sel5, par_dis, chip_pd, fdc_pd, fdc_idle, dma_req, motor_1_enable, drv1;
    logic       d23, rate0, strap, dack, printer_floppy_detect, drv2p, cs16, dskchg;
    logic [1:0] uart_pd, drid;
    logic [3:0] fdc_in;
    logic [4:0] u1_in, u2_in, par_in;
    logic [7:0] wd, rdata;
    logic       lock, illegal, i5o, i5e, i7o, i7e, dreq_oe, p43, p45, p49o, p49e, fdc_oe, par_oe, dack_i, d2_i, cs_i;
    logic       dchg_i;
    logic       dreq_o, ident, tfull, mod_en, fdc_en, m0;
    logic [1:0] smode, did;
    logic [7:0] pctl;
    logic [1:0] uart_oe, baud;
    logic [3:0] fdc_i;
    logic [4:0] u1_i, u2_i, par_i;
    int         bad_count, samples_checked, cyc, n;
    // Rows: index, write data, expected read back
    logic [23:0] rows [6] = '{24'h04E0E0, 24'h06DEDE, 24'h079B9B, 24'h094747, 24'h08005A, 24'h0AFF00};

    cfg_regs u_cfg_regs (.i_clk_sys(clk), .i_nrst(nrst), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_data_sel(sel),
        .i_cfg_wdata(wd), .o_cfg_rdata(rdata), .o_cfg_lock(lock), .o_par_ctrl(pctl), .o_sys_mode(smode),
        .o_sys_mode_illegal(illegal), .i_par_irq(par_irq), .i_par_irq_sel5(sel5), .i_par_disabled(par_dis),
        .i_chip_pd(chip_pd), .i_fdc_pd(fdc_pd), .i_fdc_idle(fdc_idle), .i_uart_pd(uart_pd), .i_ecp_dma_req(dma_req),
        .i_motor_1_enable(motor_1_enable), .i_drive_1_select(drv1), .i_drive23_access(d23), .i_rate_bit0_output(rate0),
        .i_pin_clock_divide_select(strap), .i_pin_ecp_dma_acknowledge(dack), .i_pin_printer_floppy_detect(printer_floppy_detect),
        .i_pin_drive2_present_input(drv2p), .i_pin_ata_16bit_chip_select(cs16), .i_pin_drive_id(drid),
        .i_pin_disk_change(dskchg), .i_pin_fdc_in(fdc_in), .i_pin_uart1_in(u1_in), .i_pin_uart2_in(u2_in),
        .i_pin_par_in(par_in), .o_irq5_out(i5o), .o_irq5_oe(i5e), .o_irq7_out(i7o), .o_irq7_oe(i7e),
        .o_ecp_dma_request_out(dreq_o), .o_ecp_dma_request_oe(dreq_oe), .o_pin43_out(p43), .o_pin45_out(p45),
        .o_pin49_out(p49o), .o_pin49_oe(p49e), .o_fdc_out_oe(fdc_oe), .o_uart_out_oe(uart_oe), .o_par_out_oe(par_oe),
        .o_ecp_dma_ack_int(dack_i), .o_ident_int(ident), .o_drive2_present_int(d2_i), .o_ata_16bit_int(cs_i),
        .o_drive_id_int(did), .o_tape_full_support(tfull), .o_disk_change_int(dchg_i), .o_fdc_in_int(fdc_i),
        .o_uart1_in_int(u1_i), .o_uart2_in_int(u2_i), .o_par_in_int(par_i), .o_mod_clk_en(mod_en),
        .o_fdc_clk_en(fdc_en), .o_baud_clk_en(baud));

    // ==========================================================
    // Clock, timeout and bus tasks
    always #4 clk = ~clk;
    // Whole sequence needs well under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic wrb(input logic s, input logic [7:0] v);
        @(posedge clk) begin wr <= 1'b1; sel <= s; wd <= v; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic wrr(input logic [7:0] idx, input logic [7:0] v);
        wrb(1'b0, idx);
        wrb(1'b1, v);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        wrb(1'b0, idx);
        @(posedge clk) begin rd <= 1'b1; sel <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        @(posedge clk);
        `CHK(rdata, exp)
    endtask
    // Distance in cycles between two baud pulses of the first UART
    task automatic gap(output int g);
        @(posedge clk);
        while (baud[0] !== 1'b1 && g < 400) begin @(posedge clk); g++; end
        g = 1;
        @(posedge clk);
        while (baud[0] !== 1'b1 && g < 400) begin @(posedge clk); g++; end
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        clk = 1'b0; nrst = 1'b0; {wr, rd, sel, wd} = '0; strap = 1'b1; bad_count = 0; samples_checked = 0; cyc = 0;
        {par_irq, sel5, par_dis, chip_pd, fdc_pd, fdc_idle, dma_req, motor_1_enable, drv1, d23, rate0, dack, printer_floppy_detect} = '0;
        {drv2p, cs16, dskchg, uart_pd, drid, fdc_in, u1_in, u2_in, par_in} = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        rdc(8'h06, 8'h00);
        rdc(8'h07, 8'h01);
        rdc(8'h09, 8'hC0);
        $display("test reset done");
        foreach (rows[i]) begin
            wrr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0]);
        end
        $display("test rows done");
        fdc_pd <= 1'b1; fdc_idle <= 1'b1; uart_pd <= 2'h1; par_dis <= 1'b1; u1_in <= 5'h05; u2_in <= 5'h0A;
        dskchg <= 1'b1; d23 <= 1'b1;
        chip_pd <= 1'b1; dma_req <= 1'b1; drid <= 2'h2;
        settle();
        `CHK(u1_i, 5'h1F)
        `CHK(uart_oe, 2'h2)
        `CHK(u2_i, 5'h0A)
        `CHK({fdc_oe, fdc_i, dchg_i}, 6'h1F)
        `CHK({par_oe, par_i}, {1'b0, cfg_regs_pkg::PAR_IN_BLOCKED})
        `CHK({p43, p45}, 2'h1)
        `CHK({i5e, i5o}, 2'h2)
        `CHK({d2_i, cs_i, p49e, p49o}, 4'hE)
        `CHK({dreq_o, dreq_oe, dack_i, ident}, 4'hD)
        `CHK({tfull, did}, 3'h6)
        rdc(8'h07, 8'hFB);
        rdc(8'h09, 8'h4F);
        par_irq <= 1'b1;
        settle();
        `CHK({i7e, i7o}, 2'h2)
        par_irq <= 1'b0;
        settle();
        `CHK(i7e, 1'b0)
        wrr(8'h04, 8'h20);
        settle();
        `CHK({i7e, i7o}, 2'h3)
        `CHK(pctl, 8'h20)
        wrr(8'h06, 8'h00);
        motor_1_enable <= 1'b1;
        settle();
        `CHK({dack_i, dreq_oe, p43, u1_i}, 8'hA5)
        $display("test pins done");
        wrr(8'h06, 8'h20);
        wrr(8'h06, 8'h00);
        rdc(8'h06, 8'h20);
        `CHK(lock, 1'b1)
        wrr(8'h06, 8'h24);
        rdc(8'h06, 8'h24);
        wrr(8'h07, 8'h1A);
        rdc(8'h07, 8'h7B);
        m0 = mod_en;
        @(posedge clk);
        `CHK({fdc_en, m0 ^ mod_en}, 2'h3)
        gap(n);
        gap(n);
        `CHK(n, cfg_regs_pkg::BAUD_DIV_MIDI * 2)
        wrr(8'h07, 8'h13);
        gap(n);
        gap(n);
        `CHK(n, cfg_regs_pkg::BAUD_DIV_STD * 2)
        // High rate off: floppy falls back to the divided module rate
        wrr(8'h07, 8'h11);
        @(posedge clk);
        m0 = mod_en;
        @(posedge clk);
        `CHK({fdc_en, m0 ^ mod_en}, {mod_en, 1'b1})
        $display("test lock and baud done");
        strap <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(lock, 1'b0)
        rdc(8'h06, 8'h00);
        rdc(8'h07, 8'h60);
        `CHK({tfull, did}, 3'h0)
        `CHK({fdc_en, mod_en}, 2'h3)
        gap(n);
        `CHK(n, cfg_regs_pkg::BAUD_DIV_STD)
        wrr(8'h09, 8'h80);
        #1;
        `CHK({smode, illegal}, 3'h5)
        $display("test second reset done");
        final_report();
    end
endmodule // tb_top
